// ---- udtr_cfg.svh ----
// Constants for the serial host controller: offsets, fields, timing counts
`ifndef UDTR_CFG_SVH
`define UDTR_CFG_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define UDTR_OFF_CTRL     12'h000
`define UDTR_OFF_STATUS   12'h004
`define UDTR_OFF_TXDATA   12'h008
`define UDTR_OFF_RXDATA   12'h00c

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define UDTR_CTRL_BAUD_LSB  0
`define UDTR_CTRL_FMT_LSB   4
`define UDTR_CTRL_RDY_BIT   8
`define UDTR_CTRL_HSOFF_BIT 9
`define UDTR_TX_QUERY_BIT   31
`define UDTR_CTRL_RESET     32'h0000_0115

// ------------------------------------------------------------
// Timing: 100 MHz clock, oversampling by 16
// ------------------------------------------------------------
`define UDTR_CLK_HZ       100000000
`define UDTR_OVERSAMPLE   16
`define UDTR_ABORT_CHAR   8'h03
`define UDTR_NEWLINE_CHAR 8'h0a
`define UDTR_HOLDOFF_MAX  10

`endif

// ---- udtr_dev_model.sv ----
// Behavioural model of the serial device at the far end of the link
module udtr_dev_model #(
    parameter int BIT_CYC = 10416,
    parameter int BUF_MAX = 100
) (
    // Clock
    input  wire logic       pclk,
    // Link pins seen from the device
    input  wire logic       host_txd,
    output logic            dev_txd,
    input  wire logic       host_ready,
    output logic            dev_ready,
    // Test control
    input  wire udtr_pkg::udtr_fmt_t fmt,
    input  wire logic       send_go,
    input  wire logic [7:0] send_char,
    input  wire logic       hold_query,
    // Results
    output logic [7:0]      got_char,
    output logic            got_ok,
    output logic [7:0]      got_cnt
);
    int         buf_cnt = 0;
    int         nb;
    int         i;
    int         k;
    logic       query = 1'b0;
    logic       susp = 1'b0;
    logic [7:0] d;
    logic       ok;

    assign nb = (fmt == udtr_pkg::FMT_NONE8) ? 8 : 7;
    // Hold-off: buffer full, answer pending or own output stalled
    assign dev_ready = buf_cnt < BUF_MAX && !query && !susp;

    // A processed query holds the line until an abort clears it
    always @(posedge hold_query) query = 1'b1;

    // Receiver; the buffer takes characters even while held off
    initial begin
        got_cnt = 8'h0;
        got_ok = 1'b0;
        got_char = 8'h0;
        forever begin
            @(negedge host_txd);
            repeat (BIT_CYC / 2) @(posedge pclk);
            ok = !host_txd;
            d = 8'h0;
            for (i = 0; i < nb; i++) begin
                repeat (BIT_CYC) @(posedge pclk);
                d[i] = host_txd;
            end
            if (fmt != udtr_pkg::FMT_NONE8) begin
                repeat (BIT_CYC) @(posedge pclk);
                ok &= (^d ^ host_txd) == (fmt == udtr_pkg::FMT_ODD7);
            end
            repeat (2) begin
                repeat (BIT_CYC) @(posedge pclk);
                ok &= host_txd;
            end
            if (d == 8'h03) query = 1'b0;
            else buf_cnt++;
            got_char = d;
            got_ok = ok;
            got_cnt++;
        end
    end

    // Transmitter: permission is checked before each character
    initial begin
        dev_txd = 1'b1;
        forever begin
            @(posedge send_go);
            susp = !host_ready;
            wait (host_ready);
            susp = 1'b0;
            dev_txd = 1'b0;
            repeat (BIT_CYC) @(posedge pclk);
            for (k = 0; k < nb; k++) begin
                dev_txd = send_char[k];
                repeat (BIT_CYC) @(posedge pclk);
            end
            if (fmt != udtr_pkg::FMT_NONE8) begin
                dev_txd = ^send_char[6:0] ^ (fmt == udtr_pkg::FMT_ODD7);
                repeat (BIT_CYC) @(posedge pclk);
            end
            dev_txd = 1'b1;
            repeat (2 * BIT_CYC) @(posedge pclk);
        end
    end
endmodule

// ---- udtr_host.sv ----
// Host-side serial controller with terminal-ready / set-ready handshake
//
// Behaviour
// - Rates 300 to 9600 baud selectable; 9600 after reset.
// - Formats: none/8, even/7 (default), odd/7 selectable.
// - Each frame starts with exactly one start bit.
// - Each frame ends with exactly two stop bits.
// - Parity frame: 7 data plus parity; no parity: 8 data bits.
// - Host sends characters only while device ready line is true; this design still starts up to ten after it falls.
// - After device ready falls, host stops within ten characters.
// - After a query, host reads the whole answer before sending.
// - Host ends every command string with a newline character.
// - To abort under hold-off, host first drops ready, then sends.
// - With handshake disabled, host should use 1200 baud or less.
//
// The APB slave port and the register offsets are this design's own decisions.
`include "udtr_cfg.svh"
module udtr_host (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link pins
    output logic             txd,
    input  wire logic        rxd,
    output logic             host_ready,
    input  wire logic        dev_ready
);
    // ------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------
    udtr_pkg::udtr_baud_t baud;
    udtr_pkg::udtr_fmt_t  fmt;
    logic                 rdy_en;
    logic                 hs_off;
    udtr_pkg::udtr_char_t rx_hold;
    udtr_pkg::udtr_err_t  rx_err;
    logic                 rx_ovr;
    logic                 tx_pend;
    logic [7:0]           tx_buf;
    logic                 tx_qry;
    logic                 tick;
    logic                 wr_en;
    logic                 rd_en;
    logic                 tx_take;
    logic                 rx_done;
    logic [7:0]           rx_char;
    udtr_pkg::udtr_err_t  rx_char_err;
    logic                 q_wait;
    logic [3:0]           late_cnt;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;

    udtr_tick udtr_tick_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .baud    (baud),
        .tick    (tick)
    );

    // Frame-length helper used by transmitter and receiver
    function automatic logic [3:0] data_bits(input udtr_pkg::udtr_fmt_t f);
        return (f == udtr_pkg::FMT_NONE8) ? 4'h8 : 4'h7;
    endfunction

    function automatic logic par_bit(input logic [7:0] d,
                                     input udtr_pkg::udtr_fmt_t f);
        // Odd format adds a one so the total count of ones is odd
        return (^d[6:0]) ^ (f == udtr_pkg::FMT_ODD7);
    endfunction

    // Configuration register; reset gives 9600 baud, even/7, ready on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud   <= udtr_pkg::BAUD_9600;
            fmt    <= udtr_pkg::FMT_EVEN7;
            rdy_en <= 1'b1;
            hs_off <= 1'b0;
        end else if (wr_en && paddr == `UDTR_OFF_CTRL) begin
            if (pwdata[`UDTR_CTRL_BAUD_LSB +: 3] <= 3'h5)
                baud <= udtr_pkg::udtr_baud_t'(pwdata[`UDTR_CTRL_BAUD_LSB +: 3]);
            if (pwdata[`UDTR_CTRL_FMT_LSB +: 2] != 2'h3)
                fmt <= udtr_pkg::udtr_fmt_t'(pwdata[`UDTR_CTRL_FMT_LSB +: 2]);
            rdy_en <= pwdata[`UDTR_CTRL_RDY_BIT];
            hs_off <= pwdata[`UDTR_CTRL_HSOFF_BIT];
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rxd_m, rxd_s, dev_m, dev_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_m <= 1'b1;
            rxd_s <= 1'b1;
            dev_m <= 1'b0;
            dev_s <= 1'b0;
        end else begin
            rxd_m <= rxd;
            rxd_s <= rxd_m;
            dev_m <= dev_ready;
            dev_s <= dev_m;
        end
    end

    // Our ready line is the device's permission to talk back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            host_ready <= 1'b0;
        else
            host_ready <= rdy_en;
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SHIFT = 2'b01
    } udtr_tx_st_t;
    udtr_tx_st_t tx_st;
    logic [11:0] tx_sh;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_sub;
    logic        tx_go;
    logic        tx_last;

    // Late characters tolerated after the device holds off
    assign tx_go = !hs_off ? (dev_s || late_cnt < 4'(`UDTR_HOLDOFF_MAX))
                           : 1'b1;
    // Aborts always go out so a stuck device can be released
    assign tx_take = tx_st == TX_IDLE && tx_pend && tick &&
                     (tx_go || tx_buf == `UDTR_ABORT_CHAR);
    // Leave only after the second stop bit has stood a full bit time,
    // so a queued character cannot cut it short
    assign tx_last = tx_sub == 4'hf && tx_bits == 4'h0;

    // Frame: start, data LSB first, optional parity, two stops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st   <= TX_IDLE;
            tx_sh   <= 12'hfff;
            tx_bits <= 4'h0;
            tx_sub  <= 4'h0;
            txd     <= 1'b1;
        end else begin
            unique case (tx_st)
                TX_IDLE: begin
                    txd <= 1'b1;
                    if (tx_take) begin
                        if (fmt == udtr_pkg::FMT_NONE8)
                            tx_sh <= {2'b11, tx_buf, 1'b0, 1'b1};
                        else
                            tx_sh <= {2'b11, par_bit(tx_buf, fmt),
                                      tx_buf[6:0], 1'b0, 1'b1};
                        tx_bits <= 4'h1 + data_bits(fmt) + 4'h2 + 4'h1 -
                                   ((fmt == udtr_pkg::FMT_NONE8) ? 4'h1 : 4'h0);
                        tx_sub  <= 4'hf;
                        tx_st   <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tick) begin
                        if (tx_sub == 4'hf) begin
                            txd   <= tx_sh[1];
                            tx_sh <= {1'b1, tx_sh[11:1]};
                        end
                        tx_sub <= tx_sub + 4'h1;
                        if (tx_last)
                            tx_st <= TX_IDLE;
                        else if (tx_sub == 4'hf)
                            tx_bits <= tx_bits - 4'h1;
                    end
                end
                default: tx_st <= TX_IDLE;
            endcase
        end
    end

    // Count characters started while the device holds off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            late_cnt <= 4'h0;
        else if (dev_s)
            late_cnt <= 4'h0;
        else if (tx_take && late_cnt != 4'hf)
            late_cnt <= late_cnt + 4'h1;
    end

    // Holding register; a write while a character is pending is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pend <= 1'b0;
            tx_buf  <= 8'h00;
            tx_qry  <= 1'b0;
        end else if (wr_en && paddr == `UDTR_OFF_TXDATA && !tx_pend &&
                     !(q_wait && pwdata[7:0] != `UDTR_ABORT_CHAR)) begin
            tx_pend <= 1'b1;
            tx_buf  <= pwdata[7:0];
            tx_qry  <= pwdata[`UDTR_TX_QUERY_BIT];
        end else if (tx_take) begin
            tx_pend <= 1'b0;
        end
    end

    // Query guard: a newline marked as ending a query holds new sends
    // until the answer's newline arrives; the set beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            q_wait <= 1'b0;
        else if (tx_take && tx_buf == `UDTR_ABORT_CHAR)
            q_wait <= 1'b0;
        else if (tx_take && tx_buf == `UDTR_NEWLINE_CHAR && tx_qry)
            q_wait <= 1'b1;
        else if (rx_done && rx_char == `UDTR_NEWLINE_CHAR)
            q_wait <= 1'b0;
    end

    // ------------------------------------------------------------
    // Receiver: centre sampling on the oversample tick
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } udtr_rx_st_t;
    udtr_rx_st_t rx_st;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_idx;
    logic [8:0]  rx_sh;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st       <= RX_IDLE;
            rx_sub      <= 4'h0;
            rx_idx      <= 4'h0;
            rx_sh       <= 9'h000;
            rx_done     <= 1'b0;
            rx_char     <= 8'h00;
            rx_char_err <= '0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                unique case (rx_st)
                    RX_IDLE: begin
                        rx_sub <= 4'h0;
                        if (!rxd_s)
                            rx_st <= RX_START;
                    end
                    RX_START: begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == 4'h7) begin
                            rx_sub <= 4'h0;
                            rx_idx <= 4'h0;
                            rx_st  <= rxd_s ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == 4'hf) begin
                            rx_sh  <= {rxd_s, rx_sh[8:1]};
                            rx_idx <= rx_idx + 4'h1;
                            if (rx_idx == data_bits(fmt) -
                                ((fmt == udtr_pkg::FMT_NONE8) ? 4'h1 : 4'h0))
                                rx_st <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == 4'hf) begin
                            rx_st   <= RX_IDLE;
                            rx_done <= 1'b1;
                            rx_char_err.frame_err <= !rxd_s;
                            if (fmt == udtr_pkg::FMT_NONE8) begin
                                rx_char <= rx_sh[8:1];
                                rx_char_err.parity_err <= 1'b0;
                            end else begin
                                rx_char <= {1'b0, rx_sh[7:1]};
                                rx_char_err.parity_err <= rx_sh[8] !=
                                    par_bit({1'b0, rx_sh[7:1]}, fmt);
                            end
                        end
                    end
                    default: rx_st <= RX_IDLE;
                endcase
            end
        end
    end

    // Receive holding register; a new char wins over the read that clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hold <= '0;
            rx_err  <= '0;
            rx_ovr  <= 1'b0;
        end else if (rx_done) begin
            rx_ovr        <= rx_hold.valid &&
                             !(rd_en && paddr == `UDTR_OFF_RXDATA);
            rx_hold.data  <= rx_char;
            rx_hold.valid <= 1'b1;
            rx_err        <= rx_char_err;
        end else if (rd_en && paddr == `UDTR_OFF_RXDATA) begin
            rx_hold.valid <= 1'b0;
            rx_err        <= '0;
            rx_ovr        <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read mux; unmapped reads return zero with an error response
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `UDTR_OFF_CTRL:
                    prdata <= {22'h0, hs_off, rdy_en, 2'h0, fmt, 1'b0, baud};
                `UDTR_OFF_STATUS:
                    prdata <= {24'h0, q_wait, late_cnt != 4'h0, rx_ovr,
                               rx_err.frame_err, rx_err.parity_err, dev_s,
                               rx_hold.valid, tx_pend || tx_st != TX_IDLE};
                `UDTR_OFF_RXDATA:
                    prdata <= {23'h0, rx_hold.valid, rx_hold.data};
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign pslverr = psel && penable &&
                     paddr != `UDTR_OFF_CTRL && paddr != `UDTR_OFF_STATUS &&
                     paddr != `UDTR_OFF_TXDATA && paddr != `UDTR_OFF_RXDATA;
endmodule

// ---- udtr_host_chk.sv ----
// Checker for the serial host controller: link framing and bus relations
module udtr_host_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // Serial pins
    input wire logic        txd,
    input wire logic        host_ready
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic [2:0] baud;
    logic [1:0] fmt;
    logic       want_rdy;
    logic       in_fr;
    logic [7:0] sh;
    int         fc;
    int         bc;
    wire        wr_ctrl = psel && penable && pwrite && paddr == 12'h000;

    // Bit length in clocks; divisor rounds down like the tick generator
    assign bc = 16 * (100000000 / (16 * (300 << baud)));

    // Shadow of the control word; bad codes leave the old value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud     <= 3'h5;
            fmt      <= 2'h1;
            want_rdy <= 1'b1;
        end else if (wr_ctrl) begin
            if (pwdata[2:0] <= 3'h5) baud <= pwdata[2:0];
            if (pwdata[5:4] != 2'h3) fmt <= pwdata[5:4];
            want_rdy <= pwdata[8];
        end
    end

    // Frame position, started by the first low sample on an idle line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_fr <= 1'b0;
            fc    <= 0;
        end else if (!in_fr) begin
            in_fr <= !txd;
            fc    <= 1;
        end else begin
            in_fr <= fc < 11 * bc - 1;
            fc    <= fc + 1;
        end
    end

    // Bit-centre samples; start bit is shifted out by the parity check
    always_ff @(posedge pclk) begin
        if (in_fr && fc % bc == bc / 2) sh <= {txd, sh[7:1]};
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    ready_after_reset_a: assert property (
        $rose(presetn) |=> host_ready) else $error("ready low after reset");
    ready_follow_a: assert property (
        wr_ctrl |=> ##[0:1] host_ready == want_rdy)
        else $error("ready output ignores control write");
    ready_drop_a: assert property (
        $fell(host_ready) |-> !want_rdy) else $error("ready fell unasked");
    start_bit_a: assert property (
        in_fr && fc < bc |-> !txd) else $error("start bit too short");
    stop_bits_a: assert property (
        in_fr && fc >= 9 * bc |-> txd) else $error("stop bits missing");
    bit_edge_a: assert property (
        in_fr && txd != $past(txd) |-> fc % bc == 0)
        else $error("line changed off a bit boundary");
    parity_bit_a: assert property (
        in_fr && fc == 9 * bc && fmt != 2'h0 |-> ^sh == (fmt == 2'h2))
        else $error("parity bit wrong");
    unmapped_err_a: assert property (
        psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h00c))
        else $error("error response wrong");
endmodule

bind udtr_host udtr_host_chk udtr_host_chk_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pslverr(pslverr),
    .txd(txd),
    .host_ready(host_ready)
);

// ---- udtr_host_tb_top.sv ----
// Testbench for the serial host controller against the device model
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("unexpected %s exp %h seen %h", nm, e, g); end end
module udtr_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                pclk = 1'b0;
    logic                presetn, psel, penable, pwrite;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic                pready, pslverr, er, txd, rxd;
    logic                host_ready, dev_ready, send_go, hold_query;
    udtr_pkg::udtr_fmt_t fmt;
    logic [7:0]          send_char, got_char, got_cnt;
    logic                got_ok;
    int                  miscompares = 0;
    int                  total_checks = 0;

    // 100 MHz clock
    always #5 pclk = ~pclk;

    udtr_host udtr_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
        .rxd(rxd), .host_ready(host_ready), .dev_ready(dev_ready));
    udtr_dev_model udtr_dev_model_inst (.pclk(pclk), .host_txd(txd),
        .dev_txd(rxd), .host_ready(host_ready), .dev_ready(dev_ready),
        .fmt(fmt), .send_go(send_go), .send_char(send_char),
        .hold_query(hold_query), .got_char(got_char), .got_ok(got_ok),
        .got_cnt(got_cnt));

    // Verdict and end of run
    task finish_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One bus transfer; entered just after a rising edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] dt);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so a following call never re-drives psel in one step
        @(posedge pclk);
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask

    // Poll status until a bit sets; a frame lasts about 115k clocks
    task poll(input int b);
        rd = 32'h0;
        for (int n = 0; n < 80000 && rd[b] !== 1'b1; n++)
            xfer(1'b0, 12'h004, 0);
    endtask

    task wait_cnt(input logic [7:0] c);
        for (int n = 0; n < 200000 && got_cnt !== c; n++) @(posedge pclk);
    endtask

    // Watchdog: two frames plus setup fit well inside this span
    initial begin
        repeat (600000) @(posedge pclk);
        miscompares++;
        $display("unexpected watchdog expiry");
        finish_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, send_go, hold_query} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        send_char = 8'h0;
        fmt = udtr_pkg::FMT_EVEN7;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK("ready out", 1'b1, host_ready)
        `CHK("idle line", 1'b1, txd)
        rd_chk(12'h000, 32'h115, "ctrl reset");
        rd_chk(12'h010, 32'h0, "unmapped read");
        `CHK("unmapped err", 1'b1, er)
        // Every rate code, then the refused ones keep 9600
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, 12'h000, 32'h110 | 32'(i));
            rd_chk(12'h000, 32'h110 | 32'(i > 5 ? 5 : i), "baud");
        end
        for (int j = 0; j < 4; j++) begin
            xfer(1'b1, 12'h000, 32'h305 | 32'(j << 4));
            rd_chk(12'h000, 32'h305 | 32'((j > 2 ? 2 : j) << 4), "fmt");
        end
        xfer(1'b1, 12'h000, 32'h115);
        // Both ways at once; ours is a newline marked as ending a query
        send_char <= 8'h0a;
        send_go <= 1'b1;
        xfer(1'b1, 12'h008, 32'h8000_000a);
        send_go <= 1'b0;
        // One oversample tick at 9600 baud is under 700 clocks
        repeat (700) @(posedge pclk);
        rd_chk(12'h004, 32'h85, "query wait");
        wait_cnt(8'h1);
        `CHK("tx char", 8'h0a, got_char)
        `CHK("tx frame", 1'b1, got_ok)
        poll(1);
        `CHK("rx errs", 2'h0, rd[4:3])
        rd_chk(12'h00c, 32'h10a, "rx data");
        // Device holds off for a query; our second stop bit still stands
        hold_query <= 1'b1;
        repeat (5) @(posedge pclk);
        rd_chk(12'h004, 32'h1, "status held");
        xfer(1'b1, 12'h000, 32'h025);
        repeat (3) @(posedge pclk);
        `CHK("ready dropped", 1'b0, host_ready)
        fmt <= udtr_pkg::FMT_ODD7;
        xfer(1'b1, 12'h008, 32'h03);
        wait_cnt(8'h2);
        `CHK("abort char", 8'h03, got_char)
        `CHK("abort frame", 1'b1, got_ok)
        repeat (5) @(posedge pclk);
        poll(2);
        `CHK("hold released", 1'b1, rd[2])
        finish_test();
    end
endmodule

// ---- udtr_pkg.sv ----
// Types shared by the serial host controller
package udtr_pkg;

    typedef enum logic [2:0] {
        BAUD_300  = 3'h0,
        BAUD_600  = 3'h1,
        BAUD_1200 = 3'h2,
        BAUD_2400 = 3'h3,
        BAUD_4800 = 3'h4,
        BAUD_9600 = 3'h5
    } udtr_baud_t;

    typedef enum logic [1:0] {
        FMT_NONE8 = 2'h0,
        FMT_EVEN7 = 2'h1,
        FMT_ODD7  = 2'h2
    } udtr_fmt_t;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } udtr_char_t;

    typedef struct packed {
        logic frame_err;
        logic parity_err;
    } udtr_err_t;

endpackage

// ---- udtr_tick.sv ----
// Baud-rate tick generator: one pulse per sixteenth of a bit time
`include "udtr_cfg.svh"
module udtr_tick (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Rate selection
    input  wire udtr_pkg::udtr_baud_t baud,
    // Oversample tick
    output logic                   tick
);
    logic [15:0] cnt;

    // Divisor per rate; rounded down so the bit is never too long
    function automatic logic [15:0] divisor(input udtr_pkg::udtr_baud_t b);
        int unsigned rate;
        rate = 300;
        unique case (b)
            udtr_pkg::BAUD_300:  rate = 300;
            udtr_pkg::BAUD_600:  rate = 600;
            udtr_pkg::BAUD_1200: rate = 1200;
            udtr_pkg::BAUD_2400: rate = 2400;
            udtr_pkg::BAUD_4800: rate = 4800;
            default:             rate = 9600;
        endcase
        return 16'(`UDTR_CLK_HZ / (rate * `UDTR_OVERSAMPLE));
    endfunction

    // Free-running divider; a rate change applies to the count already running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt >= divisor(baud) - 16'h0001) begin
            cnt  <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule
